// ---- core/odhi_map.vh ----
// Constants for the OLED driver host interface block
`ifndef ODHI_MAP_VH
`define ODHI_MAP_VH

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define ODHI_CMD_SOFT_RESET 8'h01
`define ODHI_CMD_DISPLAY 8'h02
`define ODHI_CMD_STANDBY 8'h03
`define ODHI_CMD_FRAME_RATE 8'h04
`define ODHI_CMD_BUS_WIDTH 8'h08
`define ODHI_CMD_NONE 8'h00

// ---------------------------------------------------------------
// Bus width codes (low two bits of the bus width parameter)
// ---------------------------------------------------------------
`define ODHI_WIDTH_8 2'h0
`define ODHI_WIDTH_16 2'h1
`define ODHI_WIDTH_6 2'h2

// ---------------------------------------------------------------
// Field positions inside parameter words
// ---------------------------------------------------------------
`define ODHI_FLD_ONOFF 0
`define ODHI_FLD_WIDTH_LO 0
`define ODHI_FLD_WIDTH_HI 1
`define ODHI_FLD_RATE_LO 0
`define ODHI_FLD_RATE_HI 7

// ---------------------------------------------------------------
// Values after hard or soft reset
// ---------------------------------------------------------------
`define ODHI_RST_WIDTH 2'h0
`define ODHI_RST_FRAME_RATE 8'h10
`define ODHI_RST_DISPLAY_ON 1'b0
`define ODHI_RST_STANDBY 1'b1
`define ODHI_RST_FULL_SIZE 1'b1

// ---------------------------------------------------------------
// Pin synchroniser layout: idle levels after reset
// {hard_reset_n, ps, c80, cs_n, a0, wr_n, rd_n, d[15:0]}
// ---------------------------------------------------------------
`define ODHI_SYNC_W 23
`define ODHI_SYNC_INIT 23'h4B0000
`define ODHI_SER_BITS 8

`endif

// ---- core/odhi_sync.v ----
// Two flip-flop synchroniser bank for asynchronous pins
`timescale 1ns/1ps
module odhi_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire i_clk, // System clock
  input wire i_rst_n, // Active-low reset, asynchronous
  input wire [W-1:0] i_async, // Pin levels from outside the domain
  output wire [W-1:0] o_sync // Synchronised levels
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage is read only by the second stage
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // odhi_sync

// ---- core/odhi_ser.v ----
// Serial receiver: eight clock framing, MSB first, write only
`timescale 1ns/1ps
`include "odhi_map.vh"
module odhi_ser (
  input wire i_clk, // System clock
  input wire i_rst_n, // Active-low reset, asynchronous
  input wire i_enable, // Serial mode with chip select low
  input wire i_sclk_rise, // Rising edge of the serial clock seen
  input wire i_sdi, // Serial data level
  input wire i_a0, // Command/data select level
  output reg o_valid, // One-cycle pulse: byte complete
  output reg o_is_cmd, // Byte is a command
  output reg [7:0] o_byte // Received byte
);

  reg [2:0] cnt_q;
  reg [6:0] shift_q;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 3'h0;
      shift_q <= 7'h00;
      o_valid <= 1'b0;
      o_is_cmd <= 1'b0;
      o_byte <= 8'h00;
    end else begin
      o_valid <= 1'b0;
      // Deselect drops a partial group so the next one starts aligned
      if (!i_enable) begin
        cnt_q <= 3'h0;
      end else if (i_sclk_rise) begin
        shift_q <= {shift_q[5:0], i_sdi};
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          o_byte <= {shift_q, i_sdi};
          o_is_cmd <= ~i_a0;
          o_valid <= 1'b1;
        end
      end
    end
  end

endmodule // odhi_ser

// ---- core/odhi_top.v ----
// Host port of the OLED driver: 8080, 6800 and serial command/data intake
// Functional notes
// - Interface strap high parallel, low serial
// - Family strap high 6800, low 8080
// - Transfers accepted only while chip select low
// - Select low means command, high means data
// - 8080 write latched on write strobe rise
// - 8080 data read completes on read rise
// - 6800 read/write: high read, low write
// - 6800 transfers complete on enable falling edge
// - Sixteen-bit data bus, driven only on reads
// - Parallel widths 6, 8, 16 both families
// - Serial: bit 1 data, bit 0 clock
// - Serial framed in groups of eight clocks
// - Serial mode never uses sixteen-bit width
// - New command overrides any earlier command
// - Command 08h changes host bus width
// - Oscillator stopped while in standby
// - Command 04h sets frame rate
// - Hard reset low initialises the device
// - Reset: display off, oscillator off, defaults
`timescale 1ns/1ps
`include "odhi_map.vh"
module odhi_top (
  input wire I_CLK, // System clock, 100 MHz
  input wire I_RESETN, // Active-low system reset
  input wire I_HARD_RESET_N, // Hard reset pin, active low
  input wire I_INTERFACE_KIND_STRAP, // High parallel, low serial
  input wire I_BUS_FAMILY_STRAP, // High 6800, low 8080
  input wire I_CHIP_SELECT_N, // Chip select, active low
  input wire I_COMMAND_DATA_SELECT, // Low command, high data
  input wire I_WRITE_STROBE_N, // 8080 write strobe / 6800 read-write
  input wire I_READ_STROBE_N, // 8080 read strobe / 6800 enable
  input wire [15:0] I_D, // Data bus input level
  output wire [15:0] O_D, // Data bus output value
  output wire O_D_OE, // Data bus output enable, high drives
  input wire [15:0] I_RD_DATA, // Read data from display memory
  input wire I_SIZE_SET, // Display size logic left full size
  output wire O_WR_VALID, // Pulse: word written by host
  output wire O_WR_IS_CMD, // Word was a command
  output wire [15:0] O_WR_DATA, // Written word, masked to width
  output wire O_RD_DONE, // Pulse: host read completed
  output wire O_CMD_OVERRIDE, // Pulse: command replaced pending one
  output wire O_WIDTH_REJECT, // Pulse: 16-bit refused in serial
  output wire [1:0] O_BUS_WIDTH, // Active bus width code
  output wire O_SERIAL_MODE, // Serial interface active
  output wire O_MODE_6800, // 6800 family active
  output wire O_DISPLAY_ON, // Display enabled
  output wire O_STANDBY, // Standby active
  output wire O_OSC_EN, // Internal oscillator running
  output wire O_FULL_SIZE, // Full-size display mode
  output wire [7:0] O_FRAME_RATE, // Frame rate setting
  output wire O_INIT // Device being initialised
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  always @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  wire [`ODHI_SYNC_W-1:0] pins_s;
  wire hard_n_s;
  wire ps_s;
  wire c80_s;
  wire cs_n_s;
  wire a0_s;
  wire wr_s;
  wire rd_s;
  wire [15:0] d_s;

  odhi_sync #(
    .W(`ODHI_SYNC_W),
    .INIT(`ODHI_SYNC_INIT)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_async({I_HARD_RESET_N, I_INTERFACE_KIND_STRAP, I_BUS_FAMILY_STRAP,
      I_CHIP_SELECT_N, I_COMMAND_DATA_SELECT, I_WRITE_STROBE_N,
      I_READ_STROBE_N, I_D}),
    .o_sync(pins_s)
  );

  assign {hard_n_s, ps_s, c80_s, cs_n_s, a0_s, wr_s, rd_s, d_s} = pins_s;

  // Previous synchronised levels for edge detection
  reg wr_p_q;
  reg rd_p_q;
  reg sclk_p_q;

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_p_q <= 1'b1;
      rd_p_q <= 1'b1;
      sclk_p_q <= 1'b0;
    end else begin
      wr_p_q <= wr_s;
      rd_p_q <= rd_s;
      sclk_p_q <= d_s[0];
    end
  end

  // ---------------------------------------------------------------
  // Mode decode and width helper
  // ---------------------------------------------------------------
  reg [1:0] width_q;
  wire par_mode = ps_s;
  wire m6800 = par_mode & c80_s;
  wire m8080 = par_mode & ~c80_s;
  wire sel = ~cs_n_s;
  wire init = ~hard_n_s;

  // Sixteen-bit setting falls back to eight bits on the serial link
  function [1:0] eff_width;
    input [1:0] w;
    input par;
    begin
      if (!par && w == `ODHI_WIDTH_16)
        eff_width = `ODHI_WIDTH_8;
      else
        eff_width = w;
    end
  endfunction

  function [15:0] mask_word;
    input [15:0] word;
    input [1:0] w;
    begin
      case (w)
        `ODHI_WIDTH_16: mask_word = word;
        `ODHI_WIDTH_6: mask_word = {10'h000, word[5:0]};
        default: mask_word = {8'h00, word[7:0]};
      endcase
    end
  endfunction

  wire [1:0] act_width = eff_width(width_q, par_mode);

  // ---------------------------------------------------------------
  // Parallel strobes
  // ---------------------------------------------------------------
  wire wr_rise = wr_s & ~wr_p_q;
  wire rd_rise = rd_s & ~rd_p_q;
  wire e_fall = ~rd_s & rd_p_q;
  wire wr80 = m8080 & sel & wr_rise;
  wire rd80 = m8080 & sel & rd_rise & a0_s;
  wire wr68 = m6800 & sel & e_fall & ~wr_s;
  wire rd68 = m6800 & sel & e_fall & wr_s & a0_s;
  wire par_wr = wr80 | wr68;

  // ---------------------------------------------------------------
  // Serial receiver
  // ---------------------------------------------------------------
  wire ser_valid;
  wire ser_is_cmd;
  wire [7:0] ser_byte;

  odhi_ser u_ser (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_enable(~par_mode & sel),
    .i_sclk_rise(d_s[0] & ~sclk_p_q),
    .i_sdi(d_s[1]),
    .i_a0(a0_s),
    .o_valid(ser_valid),
    .o_is_cmd(ser_is_cmd),
    .o_byte(ser_byte)
  );

  // Accepted word from whichever port is active
  wire acc_valid = ~init & (par_wr | (~par_mode & ser_valid));
  wire acc_cmd = par_mode ? ~a0_s : ser_is_cmd;
  wire [15:0] acc_raw = par_mode ? d_s : {8'h00, ser_byte};
  wire [15:0] acc_word = mask_word(acc_raw, act_width);

  // ---------------------------------------------------------------
  // Command and parameter decode
  // ---------------------------------------------------------------
  reg [7:0] cur_cmd_q;
  reg pending_q;
  reg display_q;
  reg standby_q;
  reg full_q;
  reg [7:0] rate_q;
  reg wr_valid_q;
  reg wr_cmd_q;
  reg [15:0] wr_data_q;
  reg override_q;
  reg reject_q;

  wire soft_rst = acc_valid & acc_cmd & (acc_word[7:0] == `ODHI_CMD_SOFT_RESET);

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cur_cmd_q <= `ODHI_CMD_NONE;
      pending_q <= 1'b0;
      width_q <= `ODHI_RST_WIDTH;
      display_q <= `ODHI_RST_DISPLAY_ON;
      standby_q <= `ODHI_RST_STANDBY;
      full_q <= `ODHI_RST_FULL_SIZE;
      rate_q <= `ODHI_RST_FRAME_RATE;
      override_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      override_q <= 1'b0;
      reject_q <= 1'b0;
      if (init || soft_rst) begin
        cur_cmd_q <= `ODHI_CMD_NONE;
        pending_q <= 1'b0;
        width_q <= `ODHI_RST_WIDTH;
        display_q <= `ODHI_RST_DISPLAY_ON;
        standby_q <= `ODHI_RST_STANDBY;
        full_q <= `ODHI_RST_FULL_SIZE;
        rate_q <= `ODHI_RST_FRAME_RATE;
      end else begin
        if (I_SIZE_SET) begin
          full_q <= 1'b0;
        end
        if (acc_valid && acc_cmd) begin
          // A pending command loses its parameter slot to the new one
          override_q <= pending_q;
          cur_cmd_q <= acc_word[7:0];
          pending_q <= 1'b1;
        end else if (acc_valid && pending_q) begin
          // Only the first word after a command is its parameter; later words are data
          pending_q <= 1'b0;
          case (cur_cmd_q)
            `ODHI_CMD_DISPLAY: begin
              display_q <= acc_word[`ODHI_FLD_ONOFF];
            end
            `ODHI_CMD_STANDBY: begin
              standby_q <= acc_word[`ODHI_FLD_ONOFF];
            end
            `ODHI_CMD_FRAME_RATE: begin
              rate_q <= acc_word[`ODHI_FLD_RATE_HI:`ODHI_FLD_RATE_LO];
            end
            `ODHI_CMD_BUS_WIDTH: begin
              if (!par_mode &&
                  acc_word[`ODHI_FLD_WIDTH_HI:`ODHI_FLD_WIDTH_LO] == `ODHI_WIDTH_16) begin
                reject_q <= 1'b1;
              end else begin
                width_q <= acc_word[`ODHI_FLD_WIDTH_HI:`ODHI_FLD_WIDTH_LO];
              end
            end
            default: begin
              pending_q <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Write and read reporting
  // ---------------------------------------------------------------
  reg rd_done_q;

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid_q <= 1'b0;
      wr_cmd_q <= 1'b0;
      wr_data_q <= 16'h0000;
      rd_done_q <= 1'b0;
    end else begin
      wr_valid_q <= acc_valid;
      rd_done_q <= ~init & (rd80 | rd68);
      if (acc_valid) begin
        wr_cmd_q <= acc_cmd;
        wr_data_q <= acc_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // Data bus drive for parallel reads
  // ---------------------------------------------------------------
  // Drive follows the synchronised strobes, so it trails the pins by
  // three cycles; well inside the output access window at 100 MHz
  reg oe_q;
  reg [15:0] dout_q;
  wire rd_phase80 = m8080 & ~rd_s;
  wire rd_phase68 = m6800 & wr_s & rd_s;
  wire drive = ~init & sel & a0_s & (rd_phase80 | rd_phase68);

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
      dout_q <= 16'h0000;
    end else begin
      oe_q <= drive;
      dout_q <= mask_word(I_RD_DATA, act_width);
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign O_D = dout_q;
  assign O_D_OE = oe_q;
  assign O_WR_VALID = wr_valid_q;
  assign O_WR_IS_CMD = wr_cmd_q;
  assign O_WR_DATA = wr_data_q;
  assign O_RD_DONE = rd_done_q;
  assign O_CMD_OVERRIDE = override_q;
  assign O_WIDTH_REJECT = reject_q;
  assign O_BUS_WIDTH = act_width;
  assign O_SERIAL_MODE = ~par_mode;
  assign O_MODE_6800 = m6800;
  assign O_DISPLAY_ON = display_q & ~standby_q;
  assign O_STANDBY = standby_q;
  assign O_OSC_EN = ~standby_q;
  assign O_FULL_SIZE = full_q;
  assign O_FRAME_RATE = rate_q;
  assign O_INIT = init;

endmodule // odhi_top

// ---- testbench/odhi_properties.sv ----
// Concurrent checks on the host port outputs
`timescale 1ns/1ps
module odhi_properties (
  input wire I_CLK, // Clock
  input wire I_RESETN, // System reset, active low
  input wire I_INTERFACE_KIND_STRAP, // Parallel or serial strap
  input wire I_BUS_FAMILY_STRAP, // 6800 or 8080 strap
  input wire I_CHIP_SELECT_N, // Chip select
  input wire I_COMMAND_DATA_SELECT, // Command/data select
  input wire O_D_OE, // Bus drive enable
  input wire O_WR_VALID, // Write pulse
  input wire [15:0] O_WR_DATA, // Written word
  input wire O_RD_DONE, // Read pulse
  input wire O_CMD_OVERRIDE, // Override pulse
  input wire O_WIDTH_REJECT, // Refused width pulse
  input wire [1:0] O_BUS_WIDTH, // Active width
  input wire O_SERIAL_MODE, // Serial active
  input wire O_MODE_6800, // 6800 active
  input wire O_DISPLAY_ON, // Display enabled
  input wire O_STANDBY, // Standby
  input wire O_OSC_EN, // Oscillator running
  input wire O_FULL_SIZE, // Full-size mode
  input wire [7:0] O_FRAME_RATE, // Frame rate
  input wire O_INIT // Initialising
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_kind_strap: assert property ($stable(I_INTERFACE_KIND_STRAP) [*6]
    |-> O_SERIAL_MODE == !I_INTERFACE_KIND_STRAP) else $error("interface kind wrong");
  chk_family_strap: assert property (I_INTERFACE_KIND_STRAP && $stable(I_BUS_FAMILY_STRAP)
    && $stable(I_INTERFACE_KIND_STRAP) [*6] |-> O_MODE_6800 == I_BUS_FAMILY_STRAP)
    else $error("bus family wrong");
  chk_cs_quiet: assert property (I_CHIP_SELECT_N [*8] |-> !O_WR_VALID && !O_RD_DONE)
    else $error("transfer without chip select");
  chk_read_select: assert property (O_RD_DONE |-> $past(I_COMMAND_DATA_SELECT, 4)
    && !$past(I_CHIP_SELECT_N, 4)) else $error("read done without data select");
  chk_drive_read: assert property (O_D_OE |-> !$past(I_CHIP_SELECT_N, 3)
    && $past(I_COMMAND_DATA_SELECT, 3)) else $error("bus driven outside a read");
  chk_pulse_one: assert property (O_WR_VALID || O_RD_DONE |=> !O_WR_VALID && !O_RD_DONE)
    else $error("transfer pulse too long");
  chk_write_mask: assert property (O_WR_VALID && O_BUS_WIDTH != 2'h1 |->
    O_WR_DATA[15:8] == 8'h00 && (O_BUS_WIDTH != 2'h2 || O_WR_DATA[7:6] == 2'h0))
    else $error("written word not masked");
  chk_serial_width: assert property (O_SERIAL_MODE |-> O_BUS_WIDTH != 2'h1)
    else $error("sixteen-bit width in serial mode");
  chk_osc_standby: assert property ((O_OSC_EN == !O_STANDBY) && (!O_STANDBY || !O_DISPLAY_ON))
    else $error("oscillator or display active in standby");
  chk_init_dflt: assert property (O_INIT [*2] |-> O_STANDBY && O_FULL_SIZE && !O_DISPLAY_ON
    && O_FRAME_RATE == 8'h10 && O_BUS_WIDTH == 2'h0) else $error("init values wrong");
  cover property (O_WR_VALID && O_SERIAL_MODE);
  cover property (O_RD_DONE && O_MODE_6800);
  cover property (O_CMD_OVERRIDE);
  cover property (O_WIDTH_REJECT);
endmodule // odhi_properties
bind odhi_top odhi_properties u_chk (.*);

// ---- testbench/odhi_host.sv ----
// Host processor model driving the 8080, 6800 and serial bus
`timescale 1ns/1ps
module odhi_host (
  input wire i_clk, // Clock
  input wire [15:0] i_d, // Device data drive
  input wire i_d_oe, // Device drives the bus
  output reg o_cs_n, // Chip select
  output reg o_a0, // Command/data select
  output reg o_wr_n, // Write strobe or read/write
  output reg o_rd_n, // Read strobe or enable
  output wire [15:0] o_bus // Resolved data bus level
);
  reg [15:0] drv_q;
  reg m68;
  reg no_cs;
  // Released lines 15:1 change, so a stale value can never pass as read data
  assign o_bus = i_d_oe ? i_d : drv_q;
  initial begin
    o_cs_n = 1'h1;
    o_a0 = 1'h0;
    o_wr_n = 1'h1;
    o_rd_n = 1'h1;
    drv_q = 16'h0000;
    m68 = 1'h0;
    no_cs = 1'h0;
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge i_clk);
      #1;
    end
  endtask
  task done_xfer;
    begin
      o_cs_n = 1'h1;
      drv_q = {~drv_q[15:1], drv_q[0]}; // Serial clock stands still
      tick(4);
    end
  endtask
  task set_mode(input m);
    begin
      m68 = m;
      o_rd_n = !m;
      tick(4);
    end
  endtask
  task wr(input sel, input [15:0] w);
    begin
      o_cs_n = no_cs;
      o_a0 = sel;
      drv_q = w;
      o_wr_n = !m68;
      tick(4);
      o_rd_n = 1'h1;
      o_wr_n = 1'h0;
      tick(4);
      o_wr_n = !m68;
      o_rd_n = !m68;
      tick(4);
      o_wr_n = 1'h1;
      done_xfer;
    end
  endtask
  task rd(output [15:0] v);
    begin
      o_cs_n = 1'h0;
      o_a0 = 1'h1;
      tick(4);
      o_rd_n = !o_rd_n;
      tick(8);
      v = o_bus;
      o_rd_n = !o_rd_n;
      tick(4);
      done_xfer;
    end
  endtask
  task ser(input sel, input [7:0] b);
    integer i;
    begin
      o_cs_n = 1'h0;
      o_a0 = sel;
      drv_q[0] = 1'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        drv_q[1] = b[i];
        tick(4);
        drv_q[0] = 1'h1;
        tick(4);
        drv_q[0] = 1'h0;
      end
      tick(4);
      done_xfer;
    end
  endtask
endmodule // odhi_host

// ---- testbench/odhi_top_test.sv ----
// Self-checking test of the host port in all three bus modes
`timescale 1ns/1ps
module odhi_top_test;
  reg clk, rstn, hrst_n, c80, sz, sermode;
  reg [15:0] v, n_wr, e_wr, n_rd, n_ovr, n_rej;
  wire cs_n, a0, wr_n, rd_n, oe, wv, wcmd, rdd, ovr, rej, ser, m68, disp, stby, osc, full, init;
  wire [15:0] bus, od, wdat;
  wire [1:0] bw;
  wire [7:0] rate;
  wire [15:0] st = {rate, bw, ser, m68, disp, stby, osc, full};
  // Strap and memory side follow the scenario's mode bits
  wire ps = ~sermode;
  wire [15:0] mem = c80 ? 16'hBEEF : 16'h1234;
  integer num_errors, n_compared;
  odhi_top u_dut (
    .I_CLK(clk), .I_RESETN(rstn), .I_HARD_RESET_N(hrst_n), .I_INTERFACE_KIND_STRAP(ps),
    .I_BUS_FAMILY_STRAP(c80), .I_CHIP_SELECT_N(cs_n), .I_COMMAND_DATA_SELECT(a0),
    .I_WRITE_STROBE_N(wr_n), .I_READ_STROBE_N(rd_n), .I_D(bus), .O_D(od), .O_D_OE(oe),
    .I_RD_DATA(mem), .I_SIZE_SET(sz), .O_WR_VALID(wv), .O_WR_IS_CMD(wcmd), .O_WR_DATA(wdat),
    .O_RD_DONE(rdd), .O_CMD_OVERRIDE(ovr), .O_WIDTH_REJECT(rej), .O_BUS_WIDTH(bw),
    .O_SERIAL_MODE(ser), .O_MODE_6800(m68), .O_DISPLAY_ON(disp), .O_STANDBY(stby),
    .O_OSC_EN(osc), .O_FULL_SIZE(full), .O_FRAME_RATE(rate), .O_INIT(init)
  );
  odhi_host u_host (.i_clk(clk), .i_d(od), .i_d_oe(oe), .o_cs_n(cs_n), .o_a0(a0),
    .o_wr_n(wr_n), .o_rd_n(rd_n), .o_bus(bus));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Pulses last one cycle, so they are counted as they pass
  always @(posedge clk) begin
    if (wv === 1'h1) n_wr = n_wr + 16'h1;
    if (rdd === 1'h1) n_rd = n_rd + 16'h1;
    if (ovr === 1'h1) n_ovr = n_ovr + 16'h1;
    if (rej === 1'h1) n_rej = n_rej + 16'h1;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task check(input [63:0] name, input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task w(input sel, input [15:0] d, input [15:0] e);
    begin
      if (sermode) u_host.ser(sel, d[7:0]);
      else u_host.wr(sel, d);
      e_wr = e_wr + 16'h1;
      check("writes", n_wr, e_wr);
      check("wdata", wdat, e);
      check("is_cmd", {15'h0, wcmd}, {15'h0, !sel});
    end
  endtask
  task cp(input [7:0] c, input [15:0] p);
    begin
      w(1'h0, {8'h00, c}, {8'h00, c});
      w(1'h1, p, p);
    end
  endtask
  task wid(input [1:0] c, input [15:0] e, input [15:0] s);
    begin
      cp(8'h08, {14'h0, c});
      w(1'h1, 16'hA5C3, e);
      check("status", st, s);
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    #900000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    {rstn, hrst_n, c80, sz, sermode} = 5'h08;
    {n_wr, e_wr, n_rd, n_ovr, n_rej} = 80'h0;
    num_errors = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'h1;
    u_host.tick(8);
    check("status", st, 16'h1005);
    cp(8'h04, 16'h0055);
    cp(8'h03, 16'h0000);
    cp(8'h02, 16'h0001);
    check("status", st, 16'h550B);
    w(1'h0, 16'h0004, 16'h0004);
    cp(8'h02, 16'h0000);
    check("override", n_ovr, 16'h1);
    check("status", st, 16'h5503);
    wid(2'h1, 16'hA5C3, 16'h5543);
    wid(2'h2, 16'h0003, 16'h5583);
    wid(2'h0, 16'h00C3, 16'h5503);
    u_host.no_cs = 1'h1;
    u_host.wr(1'h1, 16'h00AA);
    u_host.no_cs = 1'h0;
    check("writes", n_wr, e_wr);
    u_host.rd(v);
    check("rdata", v, 16'h0034);
    check("reads", n_rd, 16'h1);
    check("oe", {15'h0, oe}, 16'h0);
    $display("test 8080 done");
    c80 = 1'h1;
    u_host.set_mode(1'h1);
    wid(2'h1, 16'hA5C3, 16'h5553);
    u_host.rd(v);
    check("rdata", v, 16'hBEEF);
    check("reads", n_rd, 16'h2);
    $display("test 6800 done");
    {c80, sermode} = 2'h1;
    u_host.set_mode(1'h0);
    cp(8'h04, 16'h001D);
    sz = 1'h1;
    u_host.tick(1);
    sz = 1'h0;
    u_host.tick(2);
    check("status", st, 16'h1D22);
    cp(8'h08, 16'h0001);
    check("reject", n_rej, 16'h1);
    check("status", st, 16'h1D22);
    w(1'h0, 16'h0001, 16'h0001);
    check("status", st, 16'h1025);
    cp(8'h03, 16'h0000);
    check("status", st, 16'h1023);
    $display("test serial done");
    hrst_n = 1'h0;
    u_host.tick(6);
    check("init", {15'h0, init}, 16'h1);
    hrst_n = 1'h1;
    u_host.tick(8);
    check("status", st, 16'h1025);
    $display("test hard reset done");
    wrap_up;
  end
endmodule // odhi_top_test
